//--- rtl/cbar_accept.sv
// Message buffer table with acceptance search, masks, remote handling and
// transmit request selection, plus the receive FIFO in front of it.
// Assumes a frame engine outside that delivers received frames and takes
// transmit requests, and a CPU driving the plain configuration ports.
`timescale 1ns/1ns
`include "cbar_consts.svh"

module cbar_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module cbar_accept #(
    parameter int NBUF = 32,
    parameter int ID_W = 29,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    // Received frames from the frame engine
    input wire logic rxValid,
    output logic rxReady,
    input wire logic [ID_W-1:0] rxId,
    input wire logic rxRemote,
    input wire logic [3:0] rxDlc,
    input wire logic [63:0] rxData,
    input wire logic [15:0] rxTime,
    // Acceptance masks, four of them packed, a one bit is not compared
    input wire logic [`CBAR_MASK_COUNT*ID_W-1:0] maskWords,
    // Buffer configuration write
    input wire logic cfgWrite,
    input wire logic [$clog2(NBUF)-1:0] cfgIdx,
    input wire logic [ID_W-1:0] cfgId,
    input wire logic [`CBAR_CTL_W-1:0] cfgCtrl,
    input wire logic [2:0] cfgMaskSel,
    input wire logic [3:0] cfgDlc,
    input wire logic [63:0] cfgData,
    input wire logic cfgReady,
    // CPU flag operations
    input wire logic newDataClear,
    input wire logic trqSet,
    input wire logic [$clog2(NBUF)-1:0] flagIdx,
    // Buffer readback
    input wire logic [$clog2(NBUF)-1:0] rdIdx,
    output logic [ID_W-1:0] rdId,
    output logic [`CBAR_CTL_W-1:0] rdCtrl,
    output logic [3:0] rdDlc,
    output logic [63:0] rdData,
    output logic [15:0] rdTime,
    output logic rdNewData,
    output logic rdTrq,
    // Transmit request to the frame engine
    output logic txValid,
    output logic [$clog2(NBUF)-1:0] txIdx,
    output logic [ID_W-1:0] txId,
    output logic txRemote,
    output logic [3:0] txDlc,
    output logic [63:0] txData,
    input wire logic txDone,
    input wire logic [$clog2(NBUF)-1:0] txDoneIdx,
    // Events
    output logic rxEvent,
    output logic [$clog2(NBUF)-1:0] rxEventIdx,
    output logic txEvent
);
    localparam int IW = $clog2(NBUF);
    localparam int FW = ID_W + 1 + 4 + 64 + 16;

    logic [ID_W-1:0] bufId_reg [NBUF];
    logic [`CBAR_CTL_W-1:0] bufCtrl_reg [NBUF];
    logic [2:0] bufSel_reg [NBUF];
    logic [3:0] bufDlc_reg [NBUF];
    logic [63:0] bufData_reg [NBUF];
    logic [15:0] bufTime_reg [NBUF];
    logic [NBUF-1:0] newData_reg;
    logic [NBUF-1:0] trq_reg;
    logic [NBUF-1:0] rdy_reg;
    logic [NBUF-1:0] autoPend_reg;

    cbar_pkg::cbar_state_t state_reg;
    logic [FW-1:0] fifoOut;
    logic [FW-1:0] frame_reg;
    logic fifoValid;
    logic fifoPop;
    logic [ID_W-1:0] fId;
    logic fRemote;
    logic [3:0] fDlc;
    logic [63:0] fData;
    logic [15:0] fTime;
    logic [2:0] bufCls [NBUF];
    logic [2:0] bestCls;
    logic hit;
    logic [IW-1:0] hitIdx;
    logic hitTx;
    logic storeRx;
    logic answerSet;
    logic notifySet;

    // Receive FIFO; the search engine drains one frame every two cycles
    cbar_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .inValid(rxValid),
        .inReady(rxReady),
        .inData({rxRemote, rxId, rxDlc, rxData, rxTime}),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoOut)
    );

    assign fifoPop = (state_reg == cbar_pkg::CBAR_IDLE) && fifoValid;
    assign {fRemote, fId, fDlc, fData, fTime} = frame_reg;

    // Search engine: latch a frame, resolve it in the next cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= cbar_pkg::CBAR_IDLE;
            frame_reg <= '0;
        end else begin
            unique case (state_reg)
                cbar_pkg::CBAR_IDLE: begin
                    if (fifoValid) begin
                        frame_reg <= fifoOut;
                        state_reg <= cbar_pkg::CBAR_MATCH;
                    end
                end
                cbar_pkg::CBAR_MATCH: begin
                    state_reg <= cbar_pkg::CBAR_IDLE;
                end
            endcase
        end
    end

    // Per-buffer match class of the latched frame
    for (genvar i = 0; i < NBUF; i++) begin : g_match
        logic [ID_W-1:0] careBits;
        logic idEq;
        always_comb begin
            careBits = '1;
            if (bufSel_reg[i] != `CBAR_SEL_PLAIN) begin
                careBits = ~maskWords[bufSel_reg[i][1:0]*ID_W +: ID_W];
            end
        end
        assign idEq = ((bufId_reg[i] ^ fId) & careBits) == '0;
        always_comb begin
            bufCls[i] = `CBAR_CLS_NONE;
            if (rdy_reg[i] && idEq) begin
                if (bufCtrl_reg[i][`CBAR_CTL_TX]) begin
                    bufCls[i] = fRemote ? `CBAR_CLS_TX : `CBAR_CLS_NONE;
                end else if (bufSel_reg[i] == `CBAR_SEL_PLAIN) begin
                    bufCls[i] = `CBAR_CLS_PLAIN;
                end else begin
                    bufCls[i] = `CBAR_CLS_MASK0 + {1'b0, bufSel_reg[i][1:0]};
                end
            end
        end
    end

    // Best class first, then new-data clear, then lowest number
    always_comb begin
        logic foundClr;
        logic foundSet;
        logic [IW-1:0] idxClr;
        logic [IW-1:0] idxSet;
        foundClr = 1'b0;
        foundSet = 1'b0;
        idxClr = '0;
        idxSet = '0;
        bestCls = `CBAR_CLS_NONE;
        for (int i = 0; i < NBUF; i++) begin
            if (bufCls[i] < bestCls) begin
                bestCls = bufCls[i];
            end
        end
        for (int i = NBUF - 1; i >= 0; i--) begin
            if (bufCls[i] == bestCls && bestCls != `CBAR_CLS_NONE) begin
                if (!newData_reg[i]) begin
                    foundClr = 1'b1;
                    idxClr = IW'(i);
                end else begin
                    foundSet = 1'b1;
                    idxSet = IW'(i);
                end
            end
        end
        hit = foundClr || foundSet;
        hitIdx = foundClr ? idxClr : idxSet;
        hitTx = hit && (bestCls == `CBAR_CLS_TX);
    end

    assign storeRx = (state_reg == cbar_pkg::CBAR_MATCH) && hit && !hitTx;
    // Remote reaction of a matching transmit buffer
    assign answerSet = (state_reg == cbar_pkg::CBAR_MATCH) && hitTx
        && bufCtrl_reg[hitIdx][`CBAR_CTL_ANSWER]
        && !bufCtrl_reg[hitIdx][`CBAR_CTL_RTR];
    assign notifySet = (state_reg == cbar_pkg::CBAR_MATCH) && hitTx && !answerSet
        && bufCtrl_reg[hitIdx][`CBAR_CTL_NOTIFY];

    // Buffer content: CPU configuration, overwritten by a stored frame
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NBUF; i++) begin
                bufId_reg[i] <= '0;
                bufCtrl_reg[i] <= '0;
                bufSel_reg[i] <= `CBAR_SEL_PLAIN;
                bufDlc_reg[i] <= `CBAR_DLC_RST;
                bufData_reg[i] <= '0;
                bufTime_reg[i] <= `CBAR_TIME_RST;
                rdy_reg[i] <= 1'b0;
            end
        end else begin
            if (cfgWrite) begin
                bufId_reg[cfgIdx] <= cfgId;
                bufCtrl_reg[cfgIdx] <= cfgCtrl;
                bufSel_reg[cfgIdx] <= cfgMaskSel;
                bufDlc_reg[cfgIdx] <= cfgDlc;
                bufData_reg[cfgIdx] <= cfgData;
                rdy_reg[cfgIdx] <= cfgReady;
            end
            // Transmit-buffer matches store nothing
            if (storeRx) begin
                bufId_reg[hitIdx] <= fId;
                bufDlc_reg[hitIdx] <= fDlc;
                bufData_reg[hitIdx] <= fData;
                bufTime_reg[hitIdx] <= fTime;
                bufCtrl_reg[hitIdx][`CBAR_CTL_RTR] <= fRemote;
                if (fRemote) begin
                    bufCtrl_reg[hitIdx][`CBAR_CTL_ANSWER] <= 1'b0;
                    bufCtrl_reg[hitIdx][`CBAR_CTL_NOTIFY] <= 1'b0;
                    bufCtrl_reg[hitIdx][`CBAR_CTL_STAMP] <= 1'b0;
                end
            end
        end
    end

    // New-data flags; hardware set wins over a CPU clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            newData_reg <= '0;
        end else begin
            for (int i = 0; i < NBUF; i++) begin
                if ((storeRx || notifySet) && hitIdx == IW'(i)) begin
                    newData_reg[i] <= 1'b1;
                end else if (newDataClear && flagIdx == IW'(i)) begin
                    newData_reg[i] <= 1'b0;
                end else if (txDone && txDoneIdx == IW'(i) && autoPend_reg[i]) begin
                    newData_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Auto-answer bookkeeping, ended by the successful answer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            autoPend_reg <= '0;
        end else begin
            for (int i = 0; i < NBUF; i++) begin
                if (answerSet && hitIdx == IW'(i)) begin
                    autoPend_reg[i] <= 1'b1;
                end else if (txDone && txDoneIdx == IW'(i)) begin
                    autoPend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Transmit requests stay until sent, so a missed slot only delays them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trq_reg <= '0;
        end else begin
            for (int i = 0; i < NBUF; i++) begin
                if ((answerSet && hitIdx == IW'(i)) || (trqSet && flagIdx == IW'(i))) begin
                    trq_reg[i] <= 1'b1;
                end else if (txDone && txDoneIdx == IW'(i)) begin
                    trq_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Pick the pending ready buffer with the lowest identifier
    logic candValid;
    logic [IW-1:0] candIdx;
    always_comb begin
        candValid = 1'b0;
        candIdx = '0;
        for (int i = 0; i < NBUF; i++) begin
            if (trq_reg[i] && rdy_reg[i]
                && (!candValid || bufId_reg[i] < bufId_reg[candIdx])) begin
                candValid = 1'b1;
                candIdx = IW'(i);
            end
        end
    end

    // Registered transmit request towards the frame engine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txValid <= 1'b0;
            txIdx <= '0;
            txId <= '0;
            txRemote <= 1'b0;
            txDlc <= `CBAR_DLC_RST;
            txData <= '0;
        end else begin
            txValid <= candValid && !(txDone && txDoneIdx == candIdx);
            txIdx <= candIdx;
            txId <= bufId_reg[candIdx];
            // Receive buffer or transmit buffer with remote bit sends a remote frame
            txRemote <= !bufCtrl_reg[candIdx][`CBAR_CTL_TX]
                || bufCtrl_reg[candIdx][`CBAR_CTL_RTR];
            txDlc <= bufDlc_reg[candIdx];
            txData <= bufData_reg[candIdx];
        end
    end

    // Events: receive only for stored frames, transmit for every success
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxEvent <= 1'b0;
            rxEventIdx <= '0;
            txEvent <= 1'b0;
        end else begin
            rxEvent <= storeRx;
            rxEventIdx <= hitIdx;
            txEvent <= txDone;
        end
    end

    // Buffer readback
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdId <= '0;
            rdCtrl <= '0;
            rdDlc <= `CBAR_DLC_RST;
            rdData <= '0;
            rdTime <= `CBAR_TIME_RST;
            rdNewData <= 1'b0;
            rdTrq <= 1'b0;
        end else begin
            rdId <= bufId_reg[rdIdx];
            rdCtrl <= bufCtrl_reg[rdIdx];
            rdDlc <= bufDlc_reg[rdIdx];
            rdData <= bufData_reg[rdIdx];
            rdTime <= bufTime_reg[rdIdx];
            rdNewData <= newData_reg[rdIdx];
            rdTrq <= trq_reg[rdIdx];
        end
    end
endmodule

//--- rtl/cbar_consts.svh
// Constants of the CAN buffer acceptance and remote-frame logic.
// Assumes inclusion by bare name from the design file and the testbench.
// Behaviour
// - Data frame goes to non-masked receive buffer first, then mask 0 to 3 classes.
// - Remote frame ranks transmit buffers first, then non-masked, then masks 0 to 3.
// - A frame matching a higher class is never stored in a lower class.
// - Within a class, prefer new-data clear, then lowest buffer number.
// - All same-class matches clear: store into the lowest-numbered buffer.
// - Later frames fill ascending buffers; a cleared flag makes that buffer preferred again.
// - Non-masked receive buffer accepts only an exactly equal identifier.
// - Four acceptance masks; each receive buffer may link to any one.
// - Mask-linked buffer compares only identifier bits whose mask bit is zero.
// - Transmit request on a ready receive buffer sends a remote frame with its identifier.
// - Transmit buffer with remote bit set sends a remote frame without data.
// - Remote frame into receive buffer updates length, control, stamp, data, identifier, status.
// - Storing a remote frame clears both remote enables and the stamp select bit.
// - Remote frame stored in a receive buffer causes no automatic reaction.
// - Remote frame matching a transmit buffer leaves its content unchanged except new-data.
// - Auto-answer with remote bit clear sets request; new-data cleared after answer sent.
// - Notify enable sets new-data on remote reception unless an auto-answer applies.
// - Auto-answer is suppressed when the transmit buffer itself sends remote frames.
// - Auto-answered remote frame gives no receive event; the answer gives a transmit event.
// - A pending request may miss one arbitration but is never discarded.
`ifndef CBAR_CONSTS_SVH
`define CBAR_CONSTS_SVH

// Match classes, lower value ranks higher
`define CBAR_CLS_TX 3'h0
`define CBAR_CLS_PLAIN 3'h1
`define CBAR_CLS_MASK0 3'h2
`define CBAR_CLS_NONE 3'h7
// Mask selection code meaning no mask linked
`define CBAR_SEL_PLAIN 3'h4
// Number of acceptance masks per module
`define CBAR_MASK_COUNT 4
// Control word bit positions
`define CBAR_CTL_ANSWER 0
`define CBAR_CTL_NOTIFY 1
`define CBAR_CTL_STAMP 2
`define CBAR_CTL_RTR 3
`define CBAR_CTL_TX 4
`define CBAR_CTL_W 5
// Reset values
`define CBAR_DLC_RST 4'h0
`define CBAR_TIME_RST 16'h0000

`endif

//--- rtl/cbar_pkg.sv
// Types of the CAN buffer acceptance and remote-frame logic.
// Assumes the constants header sits beside it.
package cbar_pkg;
    // One-hot states of the receive search engine
    typedef enum logic [1:0] {
        CBAR_IDLE = 2'b01,
        CBAR_MATCH = 2'b10
    } cbar_state_t;
endpackage

//--- verif/cbar_accept_assertions.sv
// Checker on the acceptance block's ports: receive events, transmit handshake, readback.
// Assumes the top module's ports, one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cbar_accept_checker #(
    parameter int NBUF = 32,
    parameter int ID_W = 29
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic rxEvent,
    input wire logic cfgWrite,
    input wire logic [$clog2(NBUF)-1:0] cfgIdx,
    input wire logic [ID_W-1:0] cfgId,
    input wire logic [3:0] cfgDlc,
    input wire logic trqSet,
    input wire logic [$clog2(NBUF)-1:0] rdIdx,
    input wire logic [ID_W-1:0] rdId,
    input wire logic [3:0] rdDlc,
    input wire logic txValid,
    input wire logic [$clog2(NBUF)-1:0] txIdx,
    input wire logic [ID_W-1:0] txId,
    input wire logic txDone,
    input wire logic txEvent
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] pend;
    logic [5:0] rxAge;
    // Frames taken but not reported yet, and cycles since the last take
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend <= 8'h00;
            rxAge <= 6'h3f;
        end else begin
            pend <= pend + 8'(rxValid && rxReady) - 8'(rxEvent);
            rxAge <= (rxValid && rxReady) ? 6'h00 : rxAge + 6'(rxAge != 6'h3f);
        end
    end
    sequence rxTake;
        rxValid && rxReady;
    endsequence
    sequence cfgThenRead;
        cfgWrite ##1 (rdIdx == $past(cfgIdx) && !cfgWrite && rxAge == 6'h3f);
    endsequence
    rx_event_cause_a: assert property (rxEvent |-> pend != 8'h00)
        else $error("receive event without a taken frame");
    rx_min_latency_a: assert property (rxEvent && pend == 8'h01 |-> rxAge >= 6'h02)
        else $error("receive event earlier than three cycles");
    rx_event_gap_a: assert property (rxEvent |=> !rxEvent)
        else $error("receive events back to back");
    tx_event_echo_a: assert property (txDone |=> txEvent)
        else $error("sent frame not reported");
    tx_event_cause_a: assert property (txEvent |-> $past(txDone))
        else $error("transmit event without a sent frame");
    tx_request_held_a: assert property (txValid && !txDone |=> txValid)
        else $error("pending request dropped");
    tx_fields_stable_a: assert property ((txValid && !txDone && !$past(txDone)
        && rxAge == 6'h3f && !trqSet && !$past(trqSet) && !$past(trqSet, 2) && !cfgWrite
        && !$past(cfgWrite) && !$past(cfgWrite, 2)) |=> $stable(txIdx) && $stable(txId))
        else $error("offered frame changed while waiting");
    cfg_readback_a: assert property (cfgThenRead |=> rdId == $past(cfgId, 2)
        && rdDlc == $past(cfgDlc, 2))
        else $error("configured buffer reads back wrong");
    cover property (rxTake ##3 rxEvent);
endmodule
bind cbar_accept cbar_accept_checker #(.NBUF(NBUF), .ID_W(ID_W)) accChk (
    .clk_sys(clk_sys), .rst(rst), .rxValid(rxValid), .rxReady(rxReady), .rxEvent(rxEvent),
    .cfgWrite(cfgWrite), .cfgIdx(cfgIdx), .cfgId(cfgId), .cfgDlc(cfgDlc), .trqSet(trqSet),
    .rdIdx(rdIdx), .rdId(rdId), .rdDlc(rdDlc), .txValid(txValid), .txIdx(txIdx),
    .txId(txId), .txDone(txDone), .txEvent(txEvent));

//--- verif/cbar_bus_model.sv
// Far-end model: the bus side that takes transmit requests and reports them sent.
// Assumes the block's clock; waitCycles sets how slowly it answers.
`timescale 1ns/1ns
module cbar_bus_model #(
    parameter int IW = 5
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic txValid,
    input wire logic [IW-1:0] txIdx,
    input wire logic [7:0] waitCycles,
    output logic txDone,
    output logic [IW-1:0] txDoneIdx,
    output logic [7:0] sentCount
);
    logic [7:0] waitCnt;
    logic [1:0] gap;
    // Send the offered frame after the wait, then rest two cycles
    always @(posedge clk_sys) begin
        txDone <= 1'b0;
        txDoneIdx <= ~txDoneIdx; // Index is meaningless outside a done pulse
        if (rst) begin
            waitCnt <= 8'h00;
            gap <= 2'h0;
            sentCount <= 8'h00;
            txDoneIdx <= '0;
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else if (txValid) begin
            if (waitCnt >= waitCycles) begin
                txDone <= 1'b1;
                txDoneIdx <= txIdx;
                sentCount <= sentCount + 8'h01;
                waitCnt <= 8'h00;
                gap <= 2'h2;
            end else begin
                waitCnt <= waitCnt + 8'h01;
            end
        end
    end
endmodule

//--- verif/tb.sv
// Self-checking bench: classes, masks, fill order, remote handling, requests, FIFO.
// Assumes the far-end model answers transmit requests.
`timescale 1ns/1ns
`include "cbar_consts.svh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin badCount++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
    localparam int NBUF = 32;
    localparam int ID_W = 29;
    localparam int IW = $clog2(NBUF);
    localparam logic [IW:0] NONE = 6'h3f;
    localparam logic [28:0] ID_K = 29'h0000100;
    localparam logic [28:0] ID_L = 29'h0000200;
    localparam logic [28:0] ID_M = 29'h0000300;
    localparam logic [28:0] ID_N = 29'h0000400;
    localparam logic [28:0] ID_P = 29'h0000500;
    localparam logic [63:0] CFGD = 64'h0123456789abcdef;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic rxValid, rxRemote, cfgWrite, cfgReady, newDataClear, trqSet, txDone;
    logic rxReady, rdNewData, rdTrq, txValid, txRemote, rxEvent, txEvent, capRem;
    logic [ID_W-1:0] rxId, cfgId, rdId, txId, capId;
    logic [IW-1:0] cfgIdx, flagIdx, rdIdx, txIdx, txDoneIdx, rxEventIdx;
    logic [IW:0] capIdx;
    logic [3:0] rxDlc, cfgDlc, rdDlc, txDlc;
    logic [63:0] rxData, cfgData, rdData, txData, capData;
    logic [15:0] rxTime, rdTime;
    logic [`CBAR_CTL_W-1:0] cfgCtrl, rdCtrl;
    logic [2:0] cfgMaskSel;
    logic [4*ID_W-1:0] maskWords;
    logic [7:0] waitCycles, sentCount, sent0;
    logic [4:0] rows [6] = '{5'h10, 5'h11, 5'h19, 5'h12, 5'h13, 5'h1b};
    logic [5:0] expTx = 6'b010010;
    logic [5:0] expDn = 6'b101000;
    int badCount = 0;
    int numChecks = 0;
    int evCount = 0;
    int i, n, takes;
    // Clock and a count of receive events
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rxEvent === 1'b1) evCount++;
    cbar_accept #(.NBUF(NBUF), .ID_W(ID_W), .FIFO_DEPTH(16)) DUT (.clk_sys, .rst, .rxValid,
        .rxReady, .rxId, .rxRemote, .rxDlc, .rxData, .rxTime, .maskWords, .cfgWrite, .cfgIdx,
        .cfgId, .cfgCtrl, .cfgMaskSel, .cfgDlc, .cfgData, .cfgReady, .newDataClear, .trqSet,
        .flagIdx, .rdIdx, .rdId, .rdCtrl, .rdDlc, .rdData, .rdTime, .rdNewData, .rdTrq,
        .txValid, .txIdx, .txId, .txRemote, .txDlc, .txData, .txDone, .txDoneIdx, .rxEvent,
        .rxEventIdx, .txEvent);
    cbar_bus_model #(.IW(IW)) farEnd (.clk_sys, .rst, .txValid, .txIdx, .waitCycles, .txDone,
        .txDoneIdx, .sentCount);
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic hang;
        badCount++;
        wrap_up();
    endtask
    task automatic cfg(input int idx, input logic [ID_W-1:0] id, input logic [4:0] ctrl,
        input logic [2:0] sel);
        {cfgIdx, rdIdx} = {IW'(idx), IW'(idx)};
        {cfgId, cfgCtrl, cfgMaskSel, cfgDlc} = {id, ctrl, sel, 4'h8};
        cfgData = CFGD ^ 64'(idx);
        {cfgReady, cfgWrite} = 2'b11;
        tick;
        cfgWrite = 1'b0;
        tick;
    endtask
    task automatic flag(input int idx, input logic clr);
        {flagIdx, newDataClear, trqSet} = {IW'(idx), clr, !clr};
        tick;
        {newDataClear, trqSet} = 2'b00;
        tick;
    endtask
    task automatic rd(input int idx);
        rdIdx = IW'(idx);
        tick;
        tick;
    endtask
    // Offer one frame, then look for the buffer it lands in
    task automatic sendRx(input logic [ID_W-1:0] id, input logic rem, input logic [IW:0] exp);
        logic [IW:0] hit;
        hit = NONE;
        {rxId, rxRemote, rxDlc, rxTime, rxValid} = {id, rem, 4'h3, 16'h5a5a, 1'b1};
        rxData = {35'h0, id} ^ 64'hfedcba9876543210;
        for (n = 0; n < 40 && rxReady !== 1'b1; n++) tick;
        if (n == 40) hang();
        tick;
        {rxValid, rxId} = {1'b0, ~id};
        for (n = 0; n < 8; n++) begin
            tick;
            if (rxEvent === 1'b1) hit = {1'b0, rxEventIdx};
        end
        `CHK("rxEventIdx", exp, hit)
    endtask
    // Capture the offered frame and wait until it is reported sent
    task automatic txWait;
        for (n = 0; n < 40 && txValid !== 1'b1; n++) tick;
        if (n == 40) hang();
        {capIdx, capRem, capData, capId} = {1'b0, txIdx, txRemote, txData, txId};
        for (n = 0; n < 80 && txEvent !== 1'b1; n++) tick;
        if (n == 80) hang();
        tick;
    endtask
    initial begin
        {rxValid, rxRemote, cfgWrite, cfgReady, newDataClear, trqSet, rxDlc, cfgDlc} = '0;
        {rxId, cfgId, rxData, cfgData, rxTime, cfgCtrl, cfgMaskSel} = '0;
        {cfgIdx, flagIdx, rdIdx, waitCycles} = '0;
        for (i = 0; i < 4; i++) maskWords[i*ID_W +: ID_W] = ID_W'(1) << i;
        repeat (8) tick;
        rst = 1'b0;
        for (i = 0; i < 4; i++) cfg(i, ID_K, 5'h00, 3'(3 - i));
        cfg(4, ID_K, 5'h00, 3'h4);
        sendRx(ID_K, 1'b0, 6'h04);
        for (i = 0; i < 4; i++) sendRx(ID_K ^ (ID_W'(1) << i), 1'b0, 6'(3 - i));
        $display("test classes done");
        for (i = 8; i < 11; i++) cfg(i, ID_L, 5'h00, 3'h4);
        for (i = 0; i < 4; i++) sendRx(ID_L, 1'b0, (i == 3) ? 6'h08 : 6'(8 + i));
        flag(9, 1'b1);
        sendRx(ID_L, 1'b0, 6'h09);
        sendRx(ID_L, 1'b0, 6'h08);
        $display("test fill order done");
        cfg(11, ID_M, 5'h07, 3'h4);
        sendRx(ID_M, 1'b1, 6'h0b);
        rd(11);
        `CHK("rdCtrl", 5'h08, rdCtrl)
        `CHK("rdDlc", 4'h3, rdDlc)
        `CHK("rdTime", 16'h5a5a, rdTime)
        `CHK("rdData", {35'h0, ID_M} ^ 64'hfedcba9876543210, rdData)
        `CHK("rdId", ID_M, rdId)
        `CHK("rdNewData", 1'b1, rdNewData)
        `CHK("txValid", 1'b0, txValid)
        $display("test remote into receive done");
        waitCycles = 8'h1e;
        cfg(13, ID_N, 5'h00, 3'h4);
        for (i = 0; i < 6; i++) begin
            cfg(12, ID_N, rows[i], 3'h4);
            if (i != 4) flag(12, 1'b1);
            sendRx(ID_N, 1'b1, NONE);
            if (expTx[i]) begin
                txWait();
                `CHK("answer", {6'h0c, 1'b0, CFGD ^ 64'd12}, {capIdx, capRem, capData})
            end else begin
                `CHK("txValid", 1'b0, txValid)
            end
            rd(12);
            `CHK("rdNewData", expDn[i], rdNewData)
            `CHK("rdDlc", 4'h8, rdDlc)
            `CHK("rdTrq", 1'b0, rdTrq)
        end
        rd(13);
        `CHK("rdNewData", 1'b0, rdNewData)
        $display("test remote into transmit done");
        waitCycles = 8'h00;
        flag(11, 1'b0);
        txWait();
        `CHK("remote request", {6'h0b, 1'b1, ID_M}, {capIdx, capRem, capId})
        // Transmit buffer with remote bit set also sends a remote frame
        cfg(14, ID_P, 5'h18, 3'h4);
        flag(14, 1'b0);
        txWait();
        `CHK("remote send", {6'h0e, 1'b1}, {capIdx, capRem})
        repeat (64) tick;
        {waitCycles, sent0} = {8'h0c, sentCount};
        flag(14, 1'b0);
        flag(11, 1'b0);
        for (n = 0; n < 200 && sentCount !== sent0 + 8'h02; n++) tick;
        `CHK("sentCount", sent0 + 8'h02, sentCount)
        $display("test requests done");
        {rxId, rxRemote, rxValid, takes, evCount} = {ID_L, 2'b01, 64'h0};
        for (n = 0; n < 80 && rxReady === 1'b1; n++) begin
            tick;
            takes++;
        end
        rxValid = 1'b0;
        `CHK("rxReady", 1'b0, rxReady)
        for (n = 0; n < 120 && evCount < takes; n++) tick;
        `CHK("events", takes, evCount)
        `CHK("takes", 1'b1, takes >= 16)
        sendRx(ID_K ^ 29'h10, 1'b0, NONE);
        $display("test fifo done");
        wrap_up();
    end
    // Cut a hang short
    initial begin
        repeat (30000) @(posedge clk_sys);
        hang();
    end
endmodule
